// *** slx_lane_sync.sv ***
// Lane crossbar for logical lanes 6/7, lane FIFO status and sync request generation
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "slx_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module slx_lane_sync import slx_pkg::*; #(
  parameter int LANE_W = 32,
  parameter int HALF_PCLK_DIV = 1
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [`SLX_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // AXI4-Lite read
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [`SLX_ADDR_W-1:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // Deserialized physical lanes and their FIFO flags
  input wire logic [7:0][LANE_W-1:0] physical_serial_lane_in,
  input wire logic [7:0] lane_fifo_full_in,
  input wire logic [7:0] lane_fifo_empty_in,
  // Logical lanes towards the deframers
  output logic [LANE_W-1:0] logical_lane6_out,
  output logic [LANE_W-1:0] logical_lane7_out,
  // Deframer alignment loss, levels
  input wire slx_loss_t alignment_loss_in,
  // Sync requests, low asks the transmitter to resync
  output logic sync_request0_n_out,
  output logic sync_request1_n_out,
  // Interrupt
  output logic irq_out
);

  if (LANE_W < 1 || HALF_PCLK_DIV < 1) begin : g_bad_param
    $error("slx_lane_sync: LANE_W and HALF_PCLK_DIV must be at least 1");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_sync1;
  logic rst_n;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] lane_crossbar_6_7;
  logic [`SLX_MASK_W-1:0] sync_loss_mask;
  logic [7:0] sync_error_duration;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;

  //////////////////////////////////////////////////////////////////////////////
  // Write channel
  logic [`SLX_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  wire [`SLX_IDX_W-1:0] w_idx = aw_addr[`SLX_ADDR_W-1:2];
  wire do_write = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
  wire wr_en = do_write && w_lane0;
  wire hit_xbar = w_idx == `SLX_IDX_XBAR;
  wire hit_mask = w_idx == `SLX_IDX_MASK;
  wire hit_dur = w_idx == `SLX_IDX_DUR;
  wire hit_istat = w_idx == `SLX_IDX_IRQ_STAT;
  wire hit_imask = w_idx == `SLX_IDX_IRQ_MASK;
  wire w_ro = w_idx == `SLX_IDX_FULL || w_idx == `SLX_IDX_EMPTY;
  wire w_mapped = hit_xbar || hit_mask || hit_dur || hit_istat || hit_imask || w_ro;
  wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
  wire w_take = s_axi_wvalid_in && s_axi_wready_out;
  wire b_done = s_axi_bvalid_out && s_axi_bready_in;
  // Field extraction from the held write word
  wire [5:0] w_xbar_fields = w_data[`SLX_L7_HI:`SLX_L6_LO];
  wire [`SLX_MASK_W-1:0] w_mask_field = w_data[`SLX_MASK_W-1:0];
  wire [7:0] w_dur_byte = w_data[`SLX_DUR_HI:0];
  wire [`SLX_IRQ_W-1:0] w_irq_field = w_data[`SLX_IRQ_W-1:0];

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `SLX_RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_lane0 <= 1'b0;
    end else begin
      if (aw_take) begin
        s_axi_awready_out <= 1'b0;
        aw_addr <= s_axi_awaddr_in;
      end
      if (w_take) begin
        s_axi_wready_out <= 1'b0;
        w_data <= s_axi_wdata_in;
        w_lane0 <= s_axi_wstrb_in[0];
      end
      if (do_write) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= w_mapped ? `SLX_RESP_OKAY : `SLX_RESP_SLVERR;
      end
      if (b_done) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // Only byte lane 0 carries register bits; FIFO status registers ignore writes, interrupt status bits clear on a written 1
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      lane_crossbar_6_7 <= {2'h0, `SLX_L7_RST, `SLX_L6_RST};
      sync_loss_mask <= `SLX_MASK_RST;
      sync_error_duration <= `SLX_DUR_RST;
      irq_mask <= `SLX_IRQ_RST;
    end else if (wr_en) begin
      if (hit_xbar) begin
        lane_crossbar_6_7 <= {2'h0, w_xbar_fields};
      end
      if (hit_mask) begin
        sync_loss_mask <= w_mask_field;
      end
      if (hit_dur) begin
        sync_error_duration <= w_dur_byte;
      end
      if (hit_imask) begin
        irq_mask <= w_irq_field;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel; decode is pure so reads never disturb state
  wire [`SLX_IDX_W-1:0] r_idx = s_axi_araddr_in[`SLX_ADDR_W-1:2];
  logic [7:0] r_val;
  logic r_mapped;
  wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
  wire r_done = s_axi_rvalid_out && s_axi_rready_in;

  always_comb begin
    r_val = 8'h00;
    r_mapped = 1'b1;
    case (r_idx)
      `SLX_IDX_XBAR: r_val = lane_crossbar_6_7;
      `SLX_IDX_FULL: r_val = lane_fifo_full_in;
      `SLX_IDX_EMPTY: r_val = lane_fifo_empty_in;
      `SLX_IDX_MASK: r_val = {4'h0, sync_loss_mask};
      `SLX_IDX_DUR: r_val = sync_error_duration;
      `SLX_IDX_IRQ_STAT: r_val = {4'h0, irq_status};
      `SLX_IDX_IRQ_MASK: r_val = {4'h0, irq_mask};
      default: r_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `SLX_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {24'h00_0000, r_val};
      s_axi_rresp_out <= r_mapped ? `SLX_RESP_OKAY : `SLX_RESP_SLVERR;
    end else if (r_done) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Crossbar
  wire [2:0] logical_lane7_source = lane_crossbar_6_7[`SLX_L7_HI:`SLX_L7_LO];
  wire [2:0] logical_lane6_source = lane_crossbar_6_7[`SLX_L6_HI:`SLX_L6_LO];

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      logical_lane6_out <= '0;
      logical_lane7_out <= '0;
    end else begin
      logical_lane7_out <= physical_serial_lane_in[logical_lane7_source];
      logical_lane6_out <= physical_serial_lane_in[logical_lane6_source];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Half processing-clock tick; the low length counts half periods
  localparam int DIV_W = HALF_PCLK_DIV > 1 ? $clog2(HALF_PCLK_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_PCLK_DIV - 1);
  logic [DIV_W-1:0] div_cnt;
  logic half_tick;

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      half_tick <= 1'b0;
    end else begin
      half_tick <= div_cnt == DIV_LAST;
      div_cnt <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sync request generation, one per link
  wire [3:0] error_report_low_length = sync_error_duration[`SLX_DUR_HI:`SLX_DUR_LO];
  // 0.5 + code periods equals 2*code + 1 half periods
  wire [`SLX_CNT_W-1:0] low_halves = {error_report_low_length, 1'b1};
  wire [1:0] frame_loss_enable = sync_loss_mask[`SLX_FR_MASK_LO+1:`SLX_FR_MASK_LO];
  wire [1:0] multiframe_loss_enable = sync_loss_mask[`SLX_MF_MASK_LO+1:`SLX_MF_MASK_LO];
  logic [1:0] sync_low;

  for (genvar i = 0; i < 2; i++) begin : g_link
    logic [`SLX_CNT_W-1:0] low_cnt;
    wire hit = (alignment_loss_in.frame[i] && frame_loss_enable[i])
      || (alignment_loss_in.multiframe[i] && multiframe_loss_enable[i]);
    // A persisting loss keeps reloading, so the line stays low while it lasts
    wire [`SLX_CNT_W-1:0] next_low_cnt = hit ? low_halves
      : (half_tick && low_cnt != '0) ? low_cnt - 1'b1 : low_cnt;

    always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
        low_cnt <= '0;
        sync_low[i] <= 1'b0;
      end else begin
        low_cnt <= next_low_cnt;
        sync_low[i] <= next_low_cnt != '0;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      sync_request0_n_out <= 1'b1;
      sync_request1_n_out <= 1'b1;
    end else begin
      sync_request0_n_out <= ~sync_low[0];
      sync_request1_n_out <= ~sync_low[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts on rising edges of raw loss; set beats a same-cycle clear
  logic [3:0] loss_prev;
  wire [3:0] loss_now = alignment_loss_in;
  wire [3:0] loss_rise = loss_now & ~loss_prev;
  wire [3:0] irq_clear = (wr_en && hit_istat) ? w_irq_field : `SLX_IRQ_RST;
  wire [3:0] next_irq_status = (irq_status & ~irq_clear) | loss_rise;
  wire irq_pending = |(next_irq_status & irq_mask);

  // History starts at the idle level so reset release shows no false edge
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      loss_prev <= `SLX_IRQ_RST;
    end else begin
      loss_prev <= loss_now;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= `SLX_IRQ_RST;
      irq_out <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_out <= irq_pending;
    end
  end

endmodule

// *** slx_cfg.svh ***
// Register indices, field positions, reset values and bus codes for the lane crossbar block
`ifndef SLX_CFG_SVH
`define SLX_CFG_SVH
`define SLX_ADDR_W 12
`define SLX_IDX_W 10
// Register indices; byte address is four times the index
`define SLX_IDX_XBAR 10'h30b
`define SLX_IDX_FULL 10'h30c
`define SLX_IDX_EMPTY 10'h30d
`define SLX_IDX_MASK 10'h311
`define SLX_IDX_DUR 10'h312
`define SLX_IDX_IRQ_STAT 10'h320
`define SLX_IDX_IRQ_MASK 10'h321
// Crossbar fields
`define SLX_L7_HI 5
`define SLX_L7_LO 3
`define SLX_L6_HI 2
`define SLX_L6_LO 0
`define SLX_L7_RST 3'h7
`define SLX_L6_RST 3'h6
// Sync generation and interrupt fields
`define SLX_MASK_W 4
`define SLX_MASK_RST 4'h0
`define SLX_MF_MASK_LO 2
`define SLX_FR_MASK_LO 0
`define SLX_IRQ_W 4
`define SLX_IRQ_RST 4'h0
`define SLX_DUR_HI 7
`define SLX_DUR_LO 4
`define SLX_DUR_RST 8'h00
`define SLX_CNT_W 5
// Bus responses
`define SLX_RESP_OKAY 2'h0
`define SLX_RESP_SLVERR 2'h2
`endif

// *** slx_pkg.sv ***
// Types shared by the lane crossbar and sync report block
package slx_pkg;
  // Alignment loss reported by the two link deframers
  typedef struct packed {
    logic [1:0] multiframe;
    logic [1:0] frame;
  } slx_loss_t;
endpackage

// *** slx_lane_sync_props.sv ***
// Port-level checker for the lane crossbar and sync report block
`timescale 1ns/1ps
module slx_lane_sync_props import slx_pkg::*; (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Register bus
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  // Sync path
  input wire slx_loss_t alignment_loss_in,
  input wire logic sync_request0_n_out,
  input wire logic sync_request1_n_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  wire loss0 = alignment_loss_in.frame[0] | alignment_loss_in.multiframe[0];
  wire loss1 = alignment_loss_in.frame[1] | alignment_loss_in.multiframe[1];
  // Any loss restarts the count, masked or not, so it stays conservative
  logic [5:0] quiet0;
  logic [5:0] quiet1;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quiet0 <= 6'h00;
      quiet1 <= 6'h00;
    end else begin
      quiet0 <= loss0 ? 6'h00 : (quiet0 == 6'h28 ? quiet0 : quiet0 + 6'h01);
      quiet1 <= loss1 ? 6'h00 : (quiet1 == 6'h28 ? quiet1 : quiet1 + 6'h01);
    end
  end
  sequence s_fall0; $fell(sync_request0_n_out); endsequence
  sequence s_fall1; $fell(sync_request1_n_out); endsequence
  property p_aw_refuse; s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out; endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("awready high after address taken");
  property p_b_hold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_after; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out; endproperty
  a_r_after: assert property (p_r_after) else $error("read answer late");
  property p_r_hold; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_rdata_hi; s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000; endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("read data upper bits set");
  property p_sync0_cause; s_fall0 |-> $past(loss0, 2); endproperty
  a_sync0_cause: assert property (p_sync0_cause) else $error("sync 0 low without link 0 loss");
  property p_sync1_cause; s_fall1 |-> $past(loss1, 2); endproperty
  a_sync1_cause: assert property (p_sync1_cause) else $error("sync 1 low without link 1 loss");
  property p_sync0_release; quiet0 >= 6'h23 |-> sync_request0_n_out; endproperty
  a_sync0_release: assert property (p_sync0_release) else $error("sync 0 low too long");
  property p_sync1_release; quiet1 >= 6'h23 |-> sync_request1_n_out; endproperty
  a_sync1_release: assert property (p_sync1_release) else $error("sync 1 low too long");
endmodule
bind slx_lane_sync slx_lane_sync_props u_props (.clock_in, .rst_n_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .alignment_loss_in, .sync_request0_n_out,
  .sync_request1_n_out);

// *** slx_xmit_model.sv ***
// Transmitter model driving eight deserialized lanes
`timescale 1ns/1ps
module slx_xmit_model (
  // Clock and sync requests
  input wire logic clock_in,
  input wire logic sync_request0_n_in,
  input wire logic sync_request1_n_in,
  // Lane words
  output logic [7:0][31:0] lane_out
);
  logic [23:0] seq;
  initial begin
    seq = 24'h000000;
    lane_out = '0;
  end
  // Word changes every cycle while both sync requests are high, so a stale crossbar pick shows up
  always @(posedge clock_in) begin
    seq <= seq + 24'h000001;
    for (int i = 0; i < 8; i++) begin
      lane_out[i] <= (sync_request0_n_in && sync_request1_n_in) ? {seq, 8'(i)} : 32'hbcbcbcbc;
    end
  end
endmodule

// *** serial_lane_xbar_sync_report_tb.sv ***
// Self-checking testbench for the lane crossbar and sync report block
`timescale 1ns/1ps
`include "slx_cfg.svh"
module serial_lane_xbar_sync_report_tb import slx_pkg::*; ;
  logic clock_in = 0, rst_n_in = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [7:0] full = 0, empty = 0;
  logic [3:0] ws = 4'hf;
  slx_loss_t loss = '0;
  wire awr, wrd, bv, arr, rv, s0, s1, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdat, l6, l7;
  wire [7:0][31:0] lanes;
  int failures = 0, total_checks = 0;
  slx_lane_sync #(.LANE_W(32), .HALF_PCLK_DIV(1)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrd), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(br), .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rresp), .physical_serial_lane_in(lanes), .lane_fifo_full_in(full),
    .lane_fifo_empty_in(empty), .logical_lane6_out(l6), .logical_lane7_out(l7), .alignment_loss_in(loss),
    .sync_request0_n_out(s0), .sync_request1_n_out(s1), .irq_out(irq));
  slx_xmit_model u_xmit (.clock_in(clock_in), .sync_request0_n_in(s0), .sync_request1_n_in(s1), .lane_out(lanes));
  initial forever #12.5 clock_in = ~clock_in;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Both address and data offered at once, each dropped when taken
  task automatic wr(input logic [9:0] i, input logic [7:0] d, output logic [1:0] r);
    int n;
    awv <= 1; wv <= 1; br <= 1; awa <= {i, 2'b00}; wd <= {24'h0, d};
    for (n = 0; n < 50; n++) begin
      @(posedge clock_in);
      if (awv && awr) awv <= 0;
      if (wv && wrd) wv <= 0;
      if (bv) begin r = bresp; break; end
    end
    br <= 0;
    @(posedge clock_in);
    if (n == 50) begin failures++; results(); end
  endtask
  task automatic rd(input logic [9:0] i, output logic [31:0] d, output logic [1:0] r);
    int n;
    arv <= 1; rr <= 1; ara <= {i, 2'b00};
    for (n = 0; n < 50; n++) begin
      @(posedge clock_in);
      if (arv && arr) arv <= 0;
      if (rv) begin d = rdat; r = rresp; break; end
    end
    rr <= 0;
    @(posedge clock_in);
    if (n == 50) begin failures++; results(); end
  endtask
  task automatic rc(input logic [9:0] i, input logic [31:0] e);
    logic [31:0] d; logic [1:0] r;
    rd(i, d, r);
    chk(d, e);
  endtask
  task automatic t_reset;
    rc(`SLX_IDX_XBAR, 32'h3e);
    rc(`SLX_IDX_MASK, 32'h0);
    rc(`SLX_IDX_DUR, 32'h0);
    rc(`SLX_IDX_FULL, 32'h0);
    $display("reset values done");
  endtask
  task automatic t_status;
    logic [1:0] r;
    for (int i = 0; i < 8; i++) begin
      full <= 8'h01 << i; empty <= ~(8'h01 << i);
      @(posedge clock_in);
      rc(`SLX_IDX_FULL, 32'(8'h01 << i));
      rc(`SLX_IDX_EMPTY, 32'(8'(~(8'h01 << i))));
      wr(`SLX_IDX_FULL, 8'h00, r);
      rc(`SLX_IDX_FULL, 32'(8'h01 << i));
    end
    $display("fifo status done");
  endtask
  task automatic t_xbar;
    logic [1:0] r; logic [31:0] e6, e7;
    for (int n = 0; n < 8; n++) begin
      wr(`SLX_IDX_XBAR, {2'b00, 3'(n), 3'(7 - n)}, r);
      rc(`SLX_IDX_XBAR, 32'({3'(n), 3'(7 - n)}));
      @(posedge clock_in); e7 = lanes[n]; e6 = lanes[7 - n];
      @(posedge clock_in); chk(l7, e7);
      chk(l6, e6);
    end
    $display("crossbar done");
  endtask
  task automatic t_sync;
    logic [1:0] r; int n0, n1, c;
    for (int k = 0; k < 2; k++) begin
      c = k * 15;
      wr(`SLX_IDX_DUR, {4'(c), 4'h0}, r);
      for (int b = 0; b < 4; b++) begin
        wr(`SLX_IDX_MASK, 8'h01 << b, r);
        for (int j = 0; j < 4; j++) begin
          n0 = 0; n1 = 0;
          loss <= slx_loss_t'(4'h1 << j);
          @(posedge clock_in); loss <= '0;
          repeat (40) begin
            @(posedge clock_in);
            if (s0 === 1'b0) n0++;
            if (s1 === 1'b0) n1++;
          end
          chk(32'(n0), (j == b && j % 2 == 0) ? 32'(2 * c + 1) : 32'h0);
          chk(32'(n1), (j == b && j % 2 == 1) ? 32'(2 * c + 1) : 32'h0);
        end
      end
    end
    $display("sync generation done");
  endtask
  task automatic t_irq;
    logic [1:0] r; logic [31:0] d;
    wr(`SLX_IDX_MASK, 8'h00, r);
    wr(`SLX_IDX_IRQ_STAT, 8'h0f, r);
    wr(`SLX_IDX_IRQ_MASK, 8'h01, r);
    for (int j = 0; j < 2; j++) begin
      loss <= slx_loss_t'(4'h1 << j);
      @(posedge clock_in); loss <= '0;
      repeat (3) @(posedge clock_in);
      chk(irq, 1'(j == 0));
      chk(s0, 1'b1);
      rc(`SLX_IDX_IRQ_STAT, 32'h1 << j);
      wr(`SLX_IDX_IRQ_STAT, 8'h01 << j, r);
      repeat (2) @(posedge clock_in);
      chk(irq, 1'b0);
    end
    ws <= 4'h0;
    wr(`SLX_IDX_IRQ_MASK, 8'h0f, r);
    ws <= 4'hf;
    chk(r, `SLX_RESP_OKAY);
    rc(`SLX_IDX_IRQ_MASK, 32'h1);
    wr(10'h000, 8'hff, r);
    chk(r, `SLX_RESP_SLVERR);
    rd(10'h000, d, r);
    chk(r, `SLX_RESP_SLVERR);
    chk(d, 32'h0);
    $display("interrupt and unmapped done");
  endtask
  initial begin
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1;
    repeat (3) @(posedge clock_in);
    t_reset();
    t_status();
    t_xbar();
    t_sync();
    t_irq();
    results();
  end
endmodule
